// ### common/ext_irq_pkg.sv
// Constants for the external interrupt request pair: register offsets,
// field positions and reset values.
// Assumes an 8-bit register port with byte-wide offsets.
package ext_irq_pkg;

	// ********************************************************
	// Register offsets
	// ********************************************************
	localparam logic [7:0] CFG_ADDR = 8'hE4;
	localparam logic [7:0] TIMER_CTRL_ADDR = 8'hE8;
	localparam logic [7:0] STAT_ADDR = 8'hEC;
	localparam logic [7:0] MASK_ADDR = 8'hF0;
	localparam logic [7:0] SKIP_ADDR = 8'hF4;

	// ********************************************************
	// Field positions
	// ********************************************************
	localparam int SEL_W = 3;
	localparam int CFG_A_SEL_LSB = 0;
	localparam int CFG_A_POL_BIT = 3;
	localparam int CFG_B_SEL_LSB = 4;
	localparam int CFG_B_POL_BIT = 7;
	localparam int TIMER_CTRL_A_TYPE_BIT = 0;
	localparam int TIMER_CTRL_A_PEND_BIT = 1;
	localparam int TIMER_CTRL_B_TYPE_BIT = 2;
	localparam int TIMER_CTRL_B_PEND_BIT = 3;
	localparam int STAT_A_BIT = 0;
	localparam int STAT_B_BIT = 1;

	// ********************************************************
	// Reset values
	// ********************************************************
	localparam logic [7:0] CFG_RST = 8'h00;
	localparam logic [1:0] TYPE_RST = 2'h0;
	localparam logic [1:0] STAT_RST = 2'h0;
	localparam logic [1:0] MASK_RST = 2'h0;
	localparam logic [7:0] SKIP_RST = 8'h00;
	localparam logic [7:0] PIN_SYNC_RST = 8'hFF;
	localparam logic [7:0] RDATA_RST = 8'h00;

endpackage

// ### verilog/ext_request_channel.sv
// One external request input: pin selection, polarity, edge or level
// detection and the pending flag.
// Assumes portPins is already synchronised to clk_sys.
`timescale 1ns/1ps
module ext_request_channel (
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic [7:0] portPins,
	input wire logic [2:0] pinSelect,
	input wire logic polarity,
	input wire logic edgeMode,
	input wire logic vectorAck,
	input wire logic swWrite,
	input wire logic swPending,
	output logic pending,
	output logic requestEvent
);

	logic activeNow;
	logic activePrev_reg;
	logic rise;

	// ********************************************************
	// Detection
	// ********************************************************
	// Only reads the pin, so the peripheral routed there is untouched
	assign activeNow = (portPins[pinSelect] == polarity); // [R1] [R3] [R4]
	assign rise = activeNow & ~activePrev_reg; // [R11]

	// Reset high, but pinSync2_reg resets to FF, so a selected pin held low through reset is still taken as an edge two cycles after release
	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
			activePrev_reg <= 1'b1;
		else
			activePrev_reg <= activeNow;
	end

	// ********************************************************
	// Pending flag
	// ********************************************************
	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
			pending <= 1'b0;
		else if (!edgeMode)
			pending <= activeNow; // [R2] [R8]
		else if (rise)
			pending <= 1'b1; // [R11]
		else if (vectorAck)
			pending <= 1'b0; // [R7]
		else if (swWrite)
			pending <= swPending;
	end

	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
			requestEvent <= 1'b0;
		else
			requestEvent <= rise;
	end

	// ********************************************************
	// Checks
	// ********************************************************
	level_follow_a: assert property (@(posedge clk_sys) disable iff (!rst_n) // [R8]
		!edgeMode |=> pending == $past(activeNow))
		else $error("level pending does not follow input");

	edge_set_a: assert property (@(posedge clk_sys) disable iff (!rst_n) // [R11]
		edgeMode && activeNow && !$past(activeNow) |=> pending)
		else $error("edge did not set pending");

	ack_clear_a: assert property (@(posedge clk_sys) disable iff (!rst_n) // [R7]
		edgeMode && vectorAck && !rise |=> !pending)
		else $error("vector did not clear pending");

	edge_hold_a: assert property (@(posedge clk_sys) disable iff (!rst_n) // [R2]
		edgeMode && pending && !vectorAck && !swWrite |=> pending)
		else $error("edge pending dropped without clear");

endmodule // ext_request_channel

// ### verilog/external_interrupt_pair.sv
// Two external interrupt request inputs watching port 1 pins, with their
// configuration, timer-control view, skip mask and event interrupt.
// Assumes port 1 pins are asynchronous and the core pulses a vector
// acknowledge on clk_sys for one cycle when it enters a service routine.
//
// Functional notes
// R1: Each input has a polarity bit, 0 active low, 1 active high; bits 3, 7.
// R2: Type bit 1 selects edge detection, 0 level; four combinations in all.
// R3: Three-bit field picks port 1 pin n; bits 2:0 first, 6:4 second.
// R4: Inputs only observe their pin and never disturb crossbar routing.
// R5: A skipped pin is never given to a crossbar peripheral.
// R6: Pending flags sit at timer-control bits 1 and 3.
// R7: Edge mode clears the pending flag when the processor vectors.
// R8: Level mode pending reads 1 while pin active, 0 while inactive.
// R9: Source holds level request active until the processor recognises it.
// R10: Source releases request before service ends, else another request.
// R11: Edge mode synchronises the pin and sets pending on inactive-to-active.
//
// Added by the designer: the strobed register port.
`timescale 1ns/1ps
module external_interrupt_pair (
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic [7:0] port1Pins,
	input wire logic [7:0] regAddr,
	input wire logic [7:0] regWrData,
	input wire logic regWrite,
	input wire logic regRead,
	output logic [7:0] regRdData,
	input wire logic vectorAckA,
	input wire logic vectorAckB,
	output logic requestAPending,
	output logic requestBPending,
	output logic [7:0] crossbarSkip,
	output logic irqOut
);

	// ********************************************************
	// Declarations
	// ********************************************************
	logic [7:0] pinSync1_reg;
	logic [7:0] pinSync2_reg;
	logic [7:0] extIrqPinConfig_reg;
	logic [1:0] edgeSelect_reg;
	logic [1:0] irqStatus_reg;
	logic [1:0] irqStatus_next;
	logic [1:0] irqMask_reg;
	logic [7:0] crossbarSkip_reg;
	logic [7:0] regRdData_reg;
	logic irqOut_reg;
	logic [7:0] rdMux;
	logic [7:0] timerCtrlView;
	logic [1:0] pendingVec;
	logic [1:0] eventVec;
	logic [1:0] ackVec;
	logic [1:0] polVec;
	logic [2:0] selVec [2];
	logic wrCfg;
	logic wrTimerCtrl;
	logic wrStat;
	logic wrMask;
	logic wrSkip;
	logic rdStat;

	// ********************************************************
	// Pin synchroniser
	// ********************************************************
	// First stage feeds only the second stage
	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			// Idle high, so the default active-low inputs show no false request
			pinSync1_reg <= ext_irq_pkg::PIN_SYNC_RST;
			pinSync2_reg <= ext_irq_pkg::PIN_SYNC_RST;
		end
		else
		begin
			pinSync1_reg <= port1Pins; // [R11]
			pinSync2_reg <= pinSync1_reg;
		end
	end

	// ********************************************************
	// Address decode
	// ********************************************************
	assign wrCfg = regWrite && (regAddr == ext_irq_pkg::CFG_ADDR);
	assign wrTimerCtrl = regWrite && (regAddr == ext_irq_pkg::TIMER_CTRL_ADDR);
	assign wrStat = regWrite && (regAddr == ext_irq_pkg::STAT_ADDR);
	assign wrMask = regWrite && (regAddr == ext_irq_pkg::MASK_ADDR);
	assign wrSkip = regWrite && (regAddr == ext_irq_pkg::SKIP_ADDR);
	assign rdStat = regRead && (regAddr == ext_irq_pkg::STAT_ADDR);

	// ********************************************************
	// Configuration register
	// ********************************************************
	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
			extIrqPinConfig_reg <= ext_irq_pkg::CFG_RST;
		else if (wrCfg)
			extIrqPinConfig_reg <= regWrData; // [R1] [R3]
	end

	// ********************************************************
	// Timer-control type bits
	// ********************************************************
	// Only the type and pending bits belong here; the rest read zero
	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
			edgeSelect_reg <= ext_irq_pkg::TYPE_RST;
		else if (wrTimerCtrl)
		begin
			edgeSelect_reg[0] <= regWrData[ext_irq_pkg::TIMER_CTRL_A_TYPE_BIT]; // [R2]
			edgeSelect_reg[1] <= regWrData[ext_irq_pkg::TIMER_CTRL_B_TYPE_BIT]; // [R2]
		end
	end

	// ********************************************************
	// Crossbar skip mask
	// ********************************************************
	// Pins marked here are withheld from crossbar peripherals
	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
			crossbarSkip_reg <= ext_irq_pkg::SKIP_RST;
		else if (wrSkip)
			crossbarSkip_reg <= regWrData; // [R5]
	end

	assign crossbarSkip = crossbarSkip_reg; // [R5]

	// ********************************************************
	// Request channels
	// ********************************************************
	assign polVec[0] = extIrqPinConfig_reg[ext_irq_pkg::CFG_A_POL_BIT];
	assign polVec[1] = extIrqPinConfig_reg[ext_irq_pkg::CFG_B_POL_BIT];
	assign selVec[0] = extIrqPinConfig_reg[ext_irq_pkg::CFG_A_SEL_LSB +: ext_irq_pkg::SEL_W];
	assign selVec[1] = extIrqPinConfig_reg[ext_irq_pkg::CFG_B_SEL_LSB +: ext_irq_pkg::SEL_W];
	assign ackVec = {vectorAckB, vectorAckA};

	// Changing the pin select in edge mode can look like an edge
	genvar ch;
	generate
		for (ch = 0; ch < 2; ch++)
		begin : gChan
			ext_request_channel uChan (
				.clk_sys(clk_sys),
				.rst_n(rst_n),
				.portPins(pinSync2_reg),
				.pinSelect(selVec[ch]),
				.polarity(polVec[ch]),
				.edgeMode(edgeSelect_reg[ch]),
				.vectorAck(ackVec[ch]),
				.swWrite(wrTimerCtrl),
				.swPending(regWrData[ch == 0 ? ext_irq_pkg::TIMER_CTRL_A_PEND_BIT
					: ext_irq_pkg::TIMER_CTRL_B_PEND_BIT]),
				.pending(pendingVec[ch]),
				.requestEvent(eventVec[ch])
			);
		end
	endgenerate

	assign requestAPending = pendingVec[0]; // [R6]
	assign requestBPending = pendingVec[1]; // [R6]

	// ********************************************************
	// Event status and interrupt
	// ********************************************************
	// A new event in the clearing cycle survives the read
	always_comb
	begin
		if (rdStat)
			irqStatus_next = eventVec;
		else if (wrStat)
			irqStatus_next = eventVec;
		else
			irqStatus_next = irqStatus_reg | eventVec;
	end

	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
			irqStatus_reg <= ext_irq_pkg::STAT_RST;
		else
			irqStatus_reg <= irqStatus_next;
	end

	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
			irqMask_reg <= ext_irq_pkg::MASK_RST;
		else if (wrMask)
			irqMask_reg <= regWrData[1:0];
	end

	// Registered output: follows status and mask one cycle later
	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
			irqOut_reg <= 1'b0;
		else
			irqOut_reg <= |(irqStatus_reg & irqMask_reg);
	end

	assign irqOut = irqOut_reg;

	// ********************************************************
	// Read path
	// ********************************************************
	always_comb
	begin
		timerCtrlView = 8'h00;
		timerCtrlView[ext_irq_pkg::TIMER_CTRL_A_TYPE_BIT] = edgeSelect_reg[0];
		timerCtrlView[ext_irq_pkg::TIMER_CTRL_A_PEND_BIT] = pendingVec[0]; // [R6]
		timerCtrlView[ext_irq_pkg::TIMER_CTRL_B_TYPE_BIT] = edgeSelect_reg[1];
		timerCtrlView[ext_irq_pkg::TIMER_CTRL_B_PEND_BIT] = pendingVec[1]; // [R6]
	end

	always_comb
	begin
		case (regAddr)
			ext_irq_pkg::CFG_ADDR: rdMux = extIrqPinConfig_reg;
			ext_irq_pkg::TIMER_CTRL_ADDR: rdMux = timerCtrlView;
			ext_irq_pkg::STAT_ADDR: rdMux = {6'h00, irqStatus_reg};
			ext_irq_pkg::MASK_ADDR: rdMux = {6'h00, irqMask_reg};
			ext_irq_pkg::SKIP_ADDR: rdMux = crossbarSkip_reg;
			default: rdMux = 8'h00;
		endcase
	end

	// Data stand only in the cycle after the read strobe
	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
			regRdData_reg <= ext_irq_pkg::RDATA_RST;
		else if (regRead)
			regRdData_reg <= rdMux;
		else
			regRdData_reg <= 8'h00;
	end

	assign regRdData = regRdData_reg;

	// ********************************************************
	// Checks
	// ********************************************************
	cfg_readback_a: assert property (@(posedge clk_sys) disable iff (!rst_n) // [R1]
		regRead && regAddr == ext_irq_pkg::CFG_ADDR
		|=> regRdData == $past(extIrqPinConfig_reg))
		else $error("config readback wrong");

	pend_view_a: assert property (@(posedge clk_sys) disable iff (!rst_n) // [R6]
		regRead && regAddr == ext_irq_pkg::TIMER_CTRL_ADDR
		|=> regRdData[ext_irq_pkg::TIMER_CTRL_A_PEND_BIT] == $past(requestAPending)
		&& regRdData[ext_irq_pkg::TIMER_CTRL_B_PEND_BIT] == $past(requestBPending))
		else $error("pending bits misplaced in timer control");

	// Polarity is taken from the same cycle as the pin, as a config write may follow
	pin_select_a: assert property (@(posedge clk_sys) disable iff (!rst_n) // [R3]
		!edgeSelect_reg[1] && $stable(extIrqPinConfig_reg)
		|=> requestBPending == $past(pinSync2_reg[selVec[1]] == polVec[1]))
		else $error("second input watches wrong pin");

	low_active_a: assert property (@(posedge clk_sys) disable iff (!rst_n) // [R1]
		!edgeSelect_reg[0] && !polVec[0] && $stable(extIrqPinConfig_reg)
		&& !pinSync2_reg[selVec[0]] |=> requestAPending)
		else $error("active low level not pending");

	skip_hold_a: assert property (@(posedge clk_sys) disable iff (!rst_n) // [R4]
		!wrSkip |=> $stable(crossbarSkip))
		else $error("skip mask moved without a write");

	skip_write_a: assert property (@(posedge clk_sys) disable iff (!rst_n) // [R5]
		wrSkip |=> crossbarSkip == $past(regWrData))
		else $error("skip mask write lost");

	irq_level_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
		irqOut == |($past(irqStatus_reg) & $past(irqMask_reg)))
		else $error("interrupt output disagrees with status");

	event_keep_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
		rdStat && eventVec[0] |=> irqStatus_reg[0])
		else $error("event lost in clearing read");

endmodule // external_interrupt_pair

// ### verif/ext_request_source.sv
// Behavioural model of the request sources wired to the port 1 pins.
// Assumes the bench calls its tasks from one process at a time.
`timescale 1ns/1ps
module ext_request_source (
	input wire logic clk_sys,
	input wire logic vectorAck,
	output logic [7:0] pins
);
	initial pins = 8'hFF;

	task automatic setAll(input logic [7:0] v);
		@(posedge clk_sys);
		pins <= v;
	endtask

	// Level request: held until the core answers or 40 cycles pass, then withdrawn at once
	task automatic request(input int pin, input logic act);
		int n;
		n = 0;
		@(posedge clk_sys);
		pins[pin] <= act;
		do
		begin
			@(posedge clk_sys);
			n++;
		end
		while (vectorAck !== 1'b1 && n < 40);
		pins[pin] <= ~act;
	endtask
endmodule // ext_request_source

// ### verif/external_interrupt_pair_tb_top.sv
// Self-checking bench for the external interrupt request pair.
// Assumes the register port answers reads in the following cycle.
`timescale 1ns/1ps
module external_interrupt_pair_tb_top;
	typedef struct packed {logic [7:0] cfg; logic [7:0] pins; logic [1:0] pend;} row_s;
	// Every select code of both inputs, both polarities, pend is {B, A}
	row_s rows [11] = '{'{8'h00, 8'hFE, 2'h3}, '{8'h00, 8'hFF, 2'h0}, '{8'h88, 8'h01, 2'h3},
		'{8'h19, 8'h02, 2'h1}, '{8'hA2, 8'h04, 2'h2}, '{8'h3B, 8'hF7, 2'h2},
		'{8'hCC, 8'h10, 2'h3}, '{8'h5D, 8'hDF, 2'h2}, '{8'hEE, 8'h40, 2'h3},
		'{8'h7F, 8'h80, 2'h1}, '{8'h07, 8'h80, 2'h2}};
	logic clk_sys, rst_n, regWrite, regRead, vectorAckA, vectorAckB;
	logic [7:0] port1Pins, regAddr, regWrData, regRdData, crossbarSkip;
	logic requestAPending, requestBPending, irqOut;
	int err_count = 0;
	int n_compared = 0;
	int cycles = 0;

	external_interrupt_pair dut (.clk_sys(clk_sys), .rst_n(rst_n), .port1Pins(port1Pins),
		.regAddr(regAddr), .regWrData(regWrData), .regWrite(regWrite), .regRead(regRead),
		.regRdData(regRdData), .vectorAckA(vectorAckA), .vectorAckB(vectorAckB),
		.requestAPending(requestAPending), .requestBPending(requestBPending),
		.crossbarSkip(crossbarSkip), .irqOut(irqOut));
	ext_request_source src (.clk_sys(clk_sys), .vectorAck(vectorAckA), .pins(port1Pins));

	initial
	begin
		clk_sys = 1'b0;
		forever #50 clk_sys = ~clk_sys;
	end

	// ****************************************
	// Helpers
	// ****************************************
	task automatic give_verdict();
		$display("Comparisons %0d, mismatches %0d", n_compared, err_count);
		if (err_count == 0 && n_compared > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		n_compared++;
		if (got !== exp)
		begin
			err_count++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic chkP(input logic [1:0] e);
		chk({6'h00, requestBPending, requestAPending}, {6'h00, e});
	endtask

	task automatic cyc(input int n);
		repeat (n) @(posedge clk_sys);
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_sys);
		regAddr <= a;
		regWrData <= d;
		regWrite <= 1'b1;
		@(posedge clk_sys);
		regWrite <= 1'b0;
	endtask

	// Read data stand only in the cycle after the strobe
	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		@(posedge clk_sys);
		regAddr <= a;
		regRead <= 1'b1;
		@(posedge clk_sys);
		regRead <= 1'b0;
		#1 chk(regRdData, exp);
	endtask

	task automatic ack(input logic a, input logic b);
		@(posedge clk_sys);
		vectorAckA <= a;
		vectorAckB <= b;
		@(posedge clk_sys);
		vectorAckA <= 1'b0;
		vectorAckB <= 1'b0;
		#1;
	endtask

	always @(posedge clk_sys)
	begin
		cycles++;
		if (cycles == 3000)
		begin
			err_count++;
			give_verdict();
		end
	end

	// ****************************************
	// Main sequence
	// ****************************************
	initial
	begin
		rst_n = 1'b0;
		regWrite = 1'b0;
		regRead = 1'b0;
		regAddr = 8'h00;
		regWrData = 8'h00;
		vectorAckA = 1'b0;
		vectorAckB = 1'b0;
		cyc(12);
		rst_n <= 1'b1;
		rd(ext_irq_pkg::CFG_ADDR, 8'h00);
		rd(ext_irq_pkg::TIMER_CTRL_ADDR, 8'h00);
		rd(ext_irq_pkg::STAT_ADDR, 8'h00);
		rd(ext_irq_pkg::SKIP_ADDR, 8'h00);
		chk({7'h00, irqOut}, 8'h00);
		wr(8'h00, 8'h5A);
		rd(8'h00, 8'h00);
		wr(ext_irq_pkg::SKIP_ADDR, 8'hA5);
		rd(ext_irq_pkg::SKIP_ADDR, 8'hA5);
		chk(crossbarSkip, 8'hA5);
		foreach (rows[i])
		begin
			wr(ext_irq_pkg::CFG_ADDR, rows[i].cfg);
			src.setAll(rows[i].pins);
			cyc(4);
			rd(ext_irq_pkg::CFG_ADDR, rows[i].cfg);
			chkP(rows[i].pend);
			rd(ext_irq_pkg::TIMER_CTRL_ADDR,
				{4'h0, rows[i].pend[1], 1'b0, rows[i].pend[0], 1'b0});
		end
		chk(crossbarSkip, 8'hA5);
		// Level request answered by the core; the ack itself must not clear
		wr(ext_irq_pkg::CFG_ADDR, 8'h00);
		src.setAll(8'hFF);
		cyc(4);
		fork
			src.request(0, 1'b0);
			begin
				cyc(5);
				#1 chkP(2'h3);
				ack(1'b1, 1'b1);
				chkP(2'h3);
			end
		join
		cyc(4);
		#1 chkP(2'h0);
		// Edge mode, active high on pin 0, events masked first
		src.setAll(8'h00);
		cyc(4);
		wr(ext_irq_pkg::CFG_ADDR, 8'h88);
		wr(ext_irq_pkg::TIMER_CTRL_ADDR, 8'h05);
		wr(ext_irq_pkg::MASK_ADDR, 8'h00);
		wr(ext_irq_pkg::STAT_ADDR, 8'h03);
		cyc(4);
		#1 chkP(2'h0);
		src.setAll(8'h01);
		cyc(4);
		#1 chkP(2'h3);
		chk({7'h00, irqOut}, 8'h00);
		rd(ext_irq_pkg::TIMER_CTRL_ADDR, 8'h0F);
		ack(1'b1, 1'b0);
		chkP(2'h2);
		ack(1'b0, 1'b1);
		chkP(2'h0);
		cyc(4);
		#1 chkP(2'h0);
		rd(ext_irq_pkg::STAT_ADDR, 8'h03);
		rd(ext_irq_pkg::STAT_ADDR, 8'h00);
		wr(ext_irq_pkg::MASK_ADDR, 8'h01);
		src.setAll(8'h00);
		cyc(4);
		src.setAll(8'h01);
		// Event pulse, status and irqOut are each one register deep: five edges
		cyc(5);
		#1 chk({7'h00, irqOut}, 8'h01);
		rd(ext_irq_pkg::STAT_ADDR, 8'h03);
		cyc(2);
		#1 chk({7'h00, irqOut}, 8'h00);
		// Software writes the pending bits in edge mode, clearing B's while A stays set; the vector clears A
		wr(ext_irq_pkg::TIMER_CTRL_ADDR, 8'h07);
		#1 chkP(2'h1);
		ack(1'b1, 1'b0);
		chkP(2'h0);
		// Reset in mid-run returns every register to its reset value
		@(posedge clk_sys);
		rst_n <= 1'b0;
		cyc(3);
		rst_n <= 1'b1;
		cyc(1);
		#1 chkP(2'h0);
		chk({7'h00, irqOut}, 8'h00);
		rd(ext_irq_pkg::CFG_ADDR, 8'h00);
		rd(ext_irq_pkg::TIMER_CTRL_ADDR, 8'h00);
		rd(ext_irq_pkg::MASK_ADDR, 8'h00);
		rd(ext_irq_pkg::SKIP_ADDR, 8'h00);
		chk(crossbarSkip, 8'h00);
		give_verdict();
	end
endmodule // external_interrupt_pair_tb_top
